// ---- clock_gen_defines.svh ----
// Offsets, field positions, reset values and timing counts of the pin control
// Functional notes
// - Master enable low enables all, high disables
// - Four active-low bank enables, one per bank
// - Disabled bank sits in its configured state
// - Bank clocks start and stop without runts, except complementary b outputs
// - Five programmable pins, one function each
// - Enables anywhere; select0 pin one; reset one-three
// - Select1 on pin one or two by plans
// - Two plans: select1 0/1 gives profile 1/2
// - Three plans: 01,10,11 give 1,2,3; 00 reserved
// - Outputs squelched until new plan runs
// - Without reset pin, select needs power-on reset
// - No select pins: single plan, no reset needed
// - Spread low applies spread to 100 MHz outputs
// - Alarm on missing input or, in generator mode, lost lock
// - Alarm clears when input clock returns
// - Buffer mode: alarm high on input loss
// - Alarm 0 if present and, in generator mode, locked, else 1
// - Single-ended pair in phase or complementary
// - Spread only in generator mode, 31.5 kHz, 0.5%
// - No 100 MHz outputs means no spread
`ifndef CLOCK_GEN_DEFINES_SVH
`define CLOCK_GEN_DEFINES_SVH
`define ADDR_PINMAP 8'h00
`define ADDR_BANKCFG 8'h04
`define ADDR_MODE 8'h08
`define ADDR_STATUS 8'h0c
`define PINMAP_RST 20'h0_0000
`define BANKCFG_RST 20'h0_0000
`define MODE_RST 2'h2
`define BCFG_DIS_POS 0
`define BCFG_COMP_POS 8
`define BCFG_100M_POS 12
`define MODE_THREE_BIT 0
`define MODE_GEN_BIT 1
`define ALLOW_ANY 5'h1f
`define ALLOW_PIN1 5'h01
`define ALLOW_PIN2 5'h02
`define ALLOW_RESET 5'h07
`define CLK_PERIOD_NS 50
`define SETTLE_NS 1000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_WAIT 16'h0002
`define SS_RATE_HZ 31500
`define SS_DOWN_PERMIL 5
`endif

// ---- clock_gen_pkg.sv ----
// Types shared by the pin control logic and its users
package clock_gen_pkg;
  typedef enum logic [3:0] {
    FN_NONE = 4'h0,
    FN_MASTER = 4'h1,
    FN_BANK0 = 4'h2,
    FN_BANK1 = 4'h3,
    FN_BANK2 = 4'h4,
    FN_BANK3 = 4'h5,
    FN_SEL0 = 4'h6,
    FN_SEL1 = 4'h7,
    FN_RESET = 4'h8,
    FN_SPREAD = 4'h9
  } pin_func_t;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_HOLD = 3'b001,
    ST_LATCH = 3'b010,
    ST_SETTLE = 3'b011,
    ST_RUN = 3'b100,
    ST_BADCODE = 3'b101
  } plan_state_t;
  typedef enum logic [1:0] {
    DIS_LOW = 2'b00,
    DIS_HIGH = 2'b01,
    DIS_HIZ = 2'b10
  } dis_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ---- clock_gen_pin_control.sv ----
// Pin control of a quad clock generator: enables, plan select, spread, alarm
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "clock_gen_defines.svh"
module clock_gen_pin_control #(
  parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire clock_gen_pkg::reg_req_t req,
  output logic [31:0] rd_data,
  input wire logic prog_pin_one,
  input wire logic prog_pin_two,
  input wire logic prog_pin_three,
  input wire logic prog_pin_five,
  input wire logic prog_pin_six,
  input wire logic ref_present,
  input wire logic pll_locked,
  input wire logic [3:0] bank_src,
  output logic [3:0] bank_clock_a,
  output logic [3:0] bank_clock_b,
  output logic [3:0] bank_clock_oe,
  output logic [1:0] active_plan,
  output logic squelch,
  output logic [3:0] spread_bank,
  output logic input_loss_alarm
);

  // Picks the level of the first allowed pin carrying a function
  function automatic logic [1:0] pin_find(
    input logic [19:0] map,
    input logic [4:0] lv,
    input clock_gen_pkg::pin_func_t fn,
    input logic [4:0] allow
  );
    logic [1:0] r;
    r = 2'h0;
    for (int i = 4; i >= 0; i--)
    begin
      if (allow[i] && map[i*4 +: 4] == fn)
      begin
        r = {1'b1, lv[i]};
      end
    end
    return r;
  endfunction

  logic [19:0] pinmap_reg;
  logic [19:0] bankcfg_reg;
  logic [1:0] mode_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;

  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic [1:0] stat_meta_reg;
  logic [1:0] stat_sync_reg;

  clock_gen_pkg::plan_state_t state_reg;
  clock_gen_pkg::plan_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [1:0] plan_reg;
  logic [1:0] plan_next;

  logic [3:0] en_q_reg;
  logic [3:0] a_reg;
  logic [3:0] b_reg;
  logic [3:0] oe_reg;
  logic [3:0] spread_reg;
  logic los_reg;

  // Pins come from the board, so each passes two flops first
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
      stat_meta_reg <= 2'h0;
      stat_sync_reg <= 2'h0;
    end
    else
    begin
      pin_meta_reg <= {prog_pin_six, prog_pin_five, prog_pin_three,
                       prog_pin_two, prog_pin_one};
      pin_sync_reg <= pin_meta_reg;
      stat_meta_reg <= {pll_locked, ref_present};
      stat_sync_reg <= stat_meta_reg;
    end
  end

  wire three_plan = mode_reg[`MODE_THREE_BIT];
  wire gen_mode = mode_reg[`MODE_GEN_BIT];
  wire ref_ok = stat_sync_reg[0];
  wire lock_ok = stat_sync_reg[1];

  // Function decode: pin legality per function
  wire [1:0] master_hit = pin_find(pinmap_reg, pin_sync_reg,
                                   clock_gen_pkg::FN_MASTER, `ALLOW_ANY);
  wire [1:0] spread_hit = pin_find(pinmap_reg, pin_sync_reg,
                                   clock_gen_pkg::FN_SPREAD, `ALLOW_ANY);
  wire [1:0] sel0_hit = pin_find(pinmap_reg, pin_sync_reg,
                                 clock_gen_pkg::FN_SEL0, `ALLOW_PIN1);
  wire [4:0] sel1_allow = three_plan ? `ALLOW_PIN2 : `ALLOW_PIN1;
  wire [1:0] sel1_hit = pin_find(pinmap_reg, pin_sync_reg,
                                 clock_gen_pkg::FN_SEL1, sel1_allow);
  wire [1:0] reset_hit = pin_find(pinmap_reg, pin_sync_reg,
                                  clock_gen_pkg::FN_RESET, `ALLOW_RESET);
  wire [1:0] bank_hit [4];
  logic [3:0] bank_ok;

  for (genvar g = 0; g < 4; g++)
  begin : g_bank_dec
    assign bank_hit[g] = pin_find(pinmap_reg, pin_sync_reg,
      clock_gen_pkg::pin_func_t'(4'(int'(clock_gen_pkg::FN_BANK0) + g)),
      `ALLOW_ANY);
    assign bank_ok[g] = !bank_hit[g][1] || !bank_hit[g][0];
  end

  // Unassigned master counts as enabled; driven high stops all banks
  wire master_ok = !master_hit[1] || !master_hit[0];
  wire reset_high = reset_hit[1] && reset_hit[0];

  // Plan decode from the select pins
  wire sel_any = sel0_hit[1] || sel1_hit[1];
  wire [1:0] code3 = {sel1_hit[0], sel0_hit[0]};
  wire [1:0] code2 = sel1_hit[0] ? 2'h2 : 2'h1;
  wire [1:0] cand_plan = !sel_any ? 2'h1 :
                         (three_plan ? code3 : code2);
  wire cand_bad = sel_any && three_plan && (code3 == 2'h0);

  // Plan adoption sequence
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    plan_next = plan_reg;
    unique case (state_reg)
      clock_gen_pkg::ST_BOOT:
      begin
        // Let the synchronisers fill before the strap sample
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg >= `BOOT_WAIT)
        begin
          state_next = clock_gen_pkg::ST_LATCH;
        end
      end
      clock_gen_pkg::ST_HOLD:
      begin
        if (!reset_high)
        begin
          state_next = clock_gen_pkg::ST_LATCH;
        end
      end
      clock_gen_pkg::ST_LATCH:
      begin
        cnt_next = 16'h0000;
        if (cand_bad)
        begin
          state_next = clock_gen_pkg::ST_BADCODE;
        end
        else
        begin
          plan_next = cand_plan;
          state_next = clock_gen_pkg::ST_SETTLE;
        end
      end
      clock_gen_pkg::ST_BADCODE:
      begin
        if (reset_high)
        begin
          state_next = clock_gen_pkg::ST_HOLD;
        end
        else if (!cand_bad)
        begin
          state_next = clock_gen_pkg::ST_LATCH;
        end
      end
      clock_gen_pkg::ST_SETTLE:
      begin
        cnt_next = cnt_reg + 16'h0001;
        if (reset_high)
        begin
          state_next = clock_gen_pkg::ST_HOLD;
        end
        else if (cnt_reg >= 16'(SETTLE_CYCLES - 1))
        begin
          state_next = clock_gen_pkg::ST_RUN;
        end
      end
      clock_gen_pkg::ST_RUN:
      begin
        // Without a reset pin only rstn can re-sample the selects
        if (reset_high)
        begin
          state_next = clock_gen_pkg::ST_HOLD;
        end
      end
      default:
      begin
        state_next = clock_gen_pkg::ST_BOOT;
        cnt_next = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= clock_gen_pkg::ST_BOOT;
      cnt_reg <= 16'h0000;
      plan_reg <= 2'h1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      plan_reg <= plan_next;
    end
  end

  wire running = (state_reg == clock_gen_pkg::ST_RUN);
  wire [3:0] en_req = {4{running && master_ok}} & bank_ok;

  // Enable only moves while the source is low, so a high phase is
  // never cut short and no runt reaches the a pin or an in-phase b pin
  wire [3:0] en_move = ~bank_src;
  wire [3:0] en_q_next = (en_move & en_req) | (~en_move & en_q_reg);
  wire [3:0] gated = bank_src & en_q_next;
  wire [3:0] comp = bankcfg_reg[`BCFG_COMP_POS +: 4];
  wire [3:0] run_b = gated ^ comp;
  logic [3:0] dis_a;
  logic [3:0] dis_oe;

  for (genvar g = 0; g < 4; g++)
  begin : g_dis
    wire [1:0] dcode = bankcfg_reg[`BCFG_DIS_POS + 2*g +: 2];
    assign dis_a[g] = (dcode == clock_gen_pkg::DIS_HIGH);
    assign dis_oe[g] = (dcode != clock_gen_pkg::DIS_HIZ);
  end

  wire [3:0] a_next = (en_q_next & gated) | (~en_q_next & dis_a);
  wire [3:0] b_next = (en_q_next & run_b) | (~en_q_next & dis_a);
  wire [3:0] oe_next = en_q_next | dis_oe;

  // Spread only for generator-mode 100 MHz banks, enabled or not
  wire spread_req = spread_hit[1] && !spread_hit[0] && gen_mode;
  wire [3:0] spread_next = {4{spread_req}} &
                           bankcfg_reg[`BCFG_100M_POS +: 4];

  // Alarm follows the input and, in generator mode, the lock
  wire los_next = !ref_ok || (gen_mode && !lock_ok);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en_q_reg <= 4'h0;
      a_reg <= 4'h0;
      b_reg <= 4'h0;
      oe_reg <= 4'h0;
      spread_reg <= 4'h0;
      los_reg <= 1'b1;
    end
    else
    begin
      en_q_reg <= en_q_next;
      a_reg <= a_next;
      b_reg <= b_next;
      oe_reg <= oe_next;
      spread_reg <= spread_next;
      los_reg <= los_next;
    end
  end

  // Configuration port
  wire wr_pinmap = req.wr && (req.addr == `ADDR_PINMAP);
  wire wr_bankcfg = req.wr && (req.addr == `ADDR_BANKCFG);
  wire wr_mode = req.wr && (req.addr == `ADDR_MODE);
  wire [31:0] status_word = {17'h0_0000, los_reg, spread_reg,
                             state_reg, plan_reg, en_q_reg, !running};

  always_comb
  begin
    rd_data_next = 32'h0000_0000;
    if (req.rd)
    begin
      unique case (req.addr)
        `ADDR_PINMAP: rd_data_next = {12'h000, pinmap_reg};
        `ADDR_BANKCFG: rd_data_next = {12'h000, bankcfg_reg};
        `ADDR_MODE: rd_data_next = {30'h0000_0000, mode_reg};
        `ADDR_STATUS: rd_data_next = status_word;
        default: rd_data_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinmap_reg <= `PINMAP_RST;
      bankcfg_reg <= `BANKCFG_RST;
      mode_reg <= `MODE_RST;
      rd_data_reg <= 32'h0000_0000;
    end
    else
    begin
      if (wr_pinmap)
      begin
        pinmap_reg <= req.wdata[19:0];
      end
      if (wr_bankcfg)
      begin
        bankcfg_reg <= req.wdata[19:0];
      end
      if (wr_mode)
      begin
        mode_reg <= req.wdata[1:0];
      end
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign bank_clock_a = a_reg;
  assign bank_clock_b = b_reg;
  assign bank_clock_oe = oe_reg;
  assign active_plan = plan_reg;
  assign squelch = !running;
  assign spread_bank = spread_reg;
  assign input_loss_alarm = los_reg;

endmodule

// ---- clock_gen_pin_control_props.sv ----
// Port relations of the pin control block
`timescale 1ns/1ps
module clock_gen_pin_control_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ref_present,
  input wire logic pll_locked,
  input wire logic [3:0] bank_src,
  input wire logic [3:0] bank_clock_a,
  input wire logic [3:0] bank_clock_b,
  input wire logic [3:0] bank_clock_oe,
  input wire logic [1:0] active_plan,
  input wire logic squelch,
  input wire logic input_loss_alarm
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_alarm_set: assert property (
    (!ref_present) [*4] |-> input_loss_alarm) else $error("alarm not set");
  // One cycle more than the set check, as the release edge itself is lost
  a_alarm_clear: assert property (
    (ref_present && pll_locked) [*5] |-> !input_loss_alarm)
    else $error("alarm not cleared");
  a_plan_legal: assert property (
    active_plan != 2'h0) else $error("reserved plan adopted");
  a_plan_quiet: assert property (
    !squelch && !$past(squelch) |-> $stable(active_plan))
    else $error("plan changed while running");
  a_boot_squelch: assert property (
    $rose(rstn) |-> squelch [*5]) else $error("boot not squelched");
  a_rise_source: assert property (
    (bank_clock_a & ~$past(bank_clock_a) & ~$past(bank_src)) == 4'h0)
    else $error("output rose without source");
  a_no_runt: assert property (
    $rose(bank_clock_a[0]) && bank_src[0] |=> bank_clock_a[0])
    else $error("short output pulse");
  a_pair_idle: assert property (
    ((bank_clock_a ^ bank_clock_b) & ~bank_clock_oe) == 4'h0)
    else $error("undriven pair differs");
endmodule
bind clock_gen_pin_control clock_gen_pin_control_props chk (.clk, .rstn,
  .ref_present, .pll_locked, .bank_src, .bank_clock_a, .bank_clock_b,
  .bank_clock_oe, .active_plan, .squelch, .input_loss_alarm);

// ---- ctrl_model.sv ----
// Board controller model driving the programmable pins
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk,
  output logic prog_pin_one,
  output logic prog_pin_two,
  output logic prog_pin_three,
  output logic prog_pin_five,
  output logic prog_pin_six
);
  initial
  begin
    {prog_pin_two, prog_pin_one, prog_pin_three} = 3'h0;
    {prog_pin_five, prog_pin_six} = 2'h0;
  end
  task automatic set_plan(input logic [1:0] code);
    @(posedge clk);
    {prog_pin_two, prog_pin_one} <= (code == 2'h0) ? 2'h1 : code;
  endtask
  // Drives any code, the reserved one too, to probe the error hold
  task automatic set_raw(input logic [1:0] code);
    @(posedge clk);
    {prog_pin_two, prog_pin_one} <= code;
  endtask
  // Held five cycles; the latch comes only after release, the device does not time it
  task automatic pulse_reset();
    @(posedge clk);
    prog_pin_three <= 1'b1;
    repeat (5) @(posedge clk);
    prog_pin_three <= 1'b0;
  endtask
  task automatic set_aux(input logic five, input logic six);
    @(posedge clk);
    prog_pin_five <= five;
    prog_pin_six <= six;
  endtask
endmodule

// ---- clock_gen_pin_control_bench.sv ----
// Self-checking bench of the pin control block
`timescale 1ns/1ps
module clock_gen_pin_control_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  clock_gen_pkg::reg_req_t req = '0;
  logic [31:0] rd_data;
  logic prog_pin_one, prog_pin_two, prog_pin_three;
  logic prog_pin_five, prog_pin_six;
  logic ref_present = 1'b1;
  logic pll_locked = 1'b1;
  logic [3:0] bank_src = 4'h0;
  logic [3:0] bank_clock_a, bank_clock_b, bank_clock_oe, spread_bank;
  logic [1:0] active_plan;
  logic squelch, input_loss_alarm;
  logic [31:0] rng = 32'h50cd_004e;
  int n_fail = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  always @(posedge clk) bank_src <= {bank_src[2:0], ~bank_src[3]};
  ctrl_model far (.clk, .prog_pin_one, .prog_pin_two, .prog_pin_three,
    .prog_pin_five, .prog_pin_six);
  clock_gen_pin_control #(.SETTLE_CYCLES(3)) uut (.clk, .rstn, .req,
    .rd_data, .prog_pin_one, .prog_pin_two, .prog_pin_three,
    .prog_pin_five, .prog_pin_six, .ref_present, .pll_locked, .bank_src,
    .bank_clock_a, .bank_clock_b, .bank_clock_oe, .active_plan, .squelch,
    .spread_bank, .input_loss_alarm);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [3:0] exp_oe(input int code);
    return (code == 1) ? 4'h0 : 4'hf & ~(4'h1 << (code - 2));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  task automatic wait_run();
    int i;
    // Look just after the edge, never in the step that moves squelch
    for (i = 0; i < 200 && squelch !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (squelch !== 1'b0)
    begin
      n_fail++;
      test_done();
    end
  endtask
  initial
  begin
    cyc(20000);
    n_fail++;
    test_done();
  end
  initial
  begin
    int k;
    int code;
    cyc(8);
    rstn <= 1'b1;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h2);
    rd_chk(8'h10, 32'h0);
    wait_run();
    chk(active_plan, 2'h1);
    $display("done reset");
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h0000_50aa);
    wr(8'h00, 32'h0009_1876);
    for (k = 0; k < 6; k++)
    begin
      rng = xs(rng);
      code = (rng[1:0] == 2'h0) ? 3 : rng[1:0];
      far.set_plan(code[1:0]);
      far.pulse_reset();
      #1 chk(squelch, 1'b1);
      wait_run();
      chk(active_plan, code[1:0]);
    end
    far.set_raw(2'h0);
    far.pulse_reset();
    cyc(20);
    chk(squelch, 1'b1);
    chk(active_plan, code[1:0]);
    far.set_plan(code[1:0]);
    wait_run();
    chk(active_plan, code[1:0]);
    wr(8'h00, 32'h0009_1076);
    far.set_plan(code[1:0] ^ 2'h3);
    cyc(8);
    chk(active_plan, code[1:0]);
    chk(squelch, 1'b0);
    wr(8'h00, 32'h0009_1876);
    $display("done plans");
    chk(spread_bank, 4'h5);
    far.set_aux(1'b0, 1'b1);
    cyc(6);
    chk(spread_bank, 4'h0);
    far.set_aux(1'b0, 1'b0);
    wr(8'h08, 32'h1);
    cyc(6);
    chk(spread_bank, 4'h0);
    wr(8'h08, 32'h3);
    $display("done spread");
    for (code = 1; code < 6; code++)
    begin
      wr(8'h00, 32'h0009_0876 | (code << 12));
      far.set_aux(1'b1, 1'b1);
      cyc(12);
      chk(bank_clock_oe, exp_oe(code));
      chk({bank_clock_a, bank_clock_b} & ~{2{exp_oe(code)}}, 0);
      far.set_aux(1'b0, 1'b1);
      cyc(12);
      chk(bank_clock_oe, 4'hf);
    end
    wr(8'h04, 32'h0000_51aa);
    cyc(2);
    #1 chk(bank_clock_b[0], {31'h0000_0000, ~bank_clock_a[0]});
    $display("done enables");
    cyc(1);
    ref_present <= 1'b0;
    cyc(5);
    chk(input_loss_alarm, 1'b1);
    ref_present <= 1'b1;
    cyc(5);
    chk(input_loss_alarm, 1'b0);
    pll_locked <= 1'b0;
    cyc(5);
    chk(input_loss_alarm, 1'b1);
    wr(8'h08, 32'h1);
    cyc(5);
    chk(input_loss_alarm, 1'b0);
    ref_present <= 1'b0;
    cyc(5);
    chk(input_loss_alarm, 1'b1);
    $display("done alarm");
    test_done();
  end
endmodule
